// [hw/rrp_drive.sv]
`timescale 1ns/10ps
`default_nettype none
module rrp_drive
    import rrp_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    rrp_link_if.drive link,
    input wire logic [1:0] stations_occupied,
    input wire logic [15:0] command_system_param,
    input wire logic [15:0] position_source_param,
    input wire logic [31:0] table_pos,
    input wire logic [15:0] table_speed,
    output logic start_pulse,
    output logic [31:0] active_pos,
    output logic [15:0] active_speed,
    output logic active_incremental,
    output logic active_from_register,
    output logic [7:0] accel_entry
);
    // The words are a mailbox the master may rewrite at any time; a
    // motion only ever sees the copy taken at its own start edge, so
    // a half-written target between two starts is harmless. Words are
    // not range checked here: the master keeps them inside the limits.

    // Stored command words, one per remote word index
    logic [15:0] pos_low_q; // Stored low word
    logic [15:0] pos_high_q; // Stored high word
    logic [15:0] speed_q; // Stored speed word
    // Start detection
    logic start_prev_q; // Start level last cycle
    logic start_edge; // Start rising edge
    // Decoded configuration, all combinational
    logic inc_system; // Incremental command system chosen
    logic src_register; // Position source set to remote words
    logic two_stations; // Footprint wide enough for remote words
    logic modes_on; // Master asks for automatic register mode
    logic reg_mode; // Register positioning active
    // What the next start edge will latch
    logic [31:0] next_pos; // Target for the next motion
    logic [15:0] next_speed; // Speed for the next motion
    logic next_incremental; // Distance rather than target

    // Lowest digit of a parameter; the upper digits set other things
    function automatic logic [3:0] low_digit(input logic [15:0] value);
        low_digit = value[RRP_DIGIT_MSB:0];
    endfunction : low_digit

    // Write strobe aimed at one word index
    function automatic logic word_hit(input logic wr,
                                      input logic [2:0] addr,
                                      input logic [2:0] idx);
        word_hit = wr && (addr == idx);
    endfunction : word_hit

    // Digit 0 picks the absolute system, digit 1 the incremental
    // Other digits are not defined; they fall back to absolute
    assign inc_system = (low_digit(command_system_param) == RRP_CMD_INC);
    // Digit 2 hands position and speed to the remote words
    assign src_register =
        (low_digit(position_source_param) == RRP_SRC_REGISTER);
    // Only the two-station footprint carries the extra words
    assign two_stations = (stations_occupied == RRP_STATIONS_REQ);
    // Automatic mode and register select both on
    assign modes_on = link.auto_manual_select
        && link.register_command_select;
    // Any one missing falls back to table positioning
    assign reg_mode = two_stations && src_register && modes_on;
    // High now and low last cycle
    assign start_edge = link.forward_start && !start_prev_q;

    // Choose where the next motion takes its target and speed
    always_comb begin
        if (reg_mode) begin
            // Target is the high word over the low word
            next_pos = {pos_high_q, pos_low_q};
            // Speed straight from its own word
            next_speed = speed_q;
        end else begin
            // Stored point table entry instead
            next_pos = table_pos;
            next_speed = table_speed;
        end
    end

    // Incremental system always moves by distance in the
    // absolute system the select bit decides
    assign next_incremental = inc_system || link.abs_inc_select;

    // Low half of the target; the master runs on this clock, so the
    // words need no synchroniser. Unmapped indices hit no store.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            // Nothing written yet
            pos_low_q <= RRP_WORD_RST;
        end else if (word_hit(link.word_wr, link.word_addr,
                              RRP_REG_POS_LOW)) begin
            // Overwrites freely; a running motion keeps its own copy
            pos_low_q <= link.word_data;
        end
    end

    // High half of the target
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            // Nothing written yet
            pos_high_q <= RRP_WORD_RST;
        end else if (word_hit(link.word_wr, link.word_addr,
                              RRP_REG_POS_HIGH)) begin
            // Sign of the target lives in this word
            pos_high_q <= link.word_data;
        end
    end

    // Speed word
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            // Nothing written yet
            speed_q <= RRP_WORD_RST;
        end else if (word_hit(link.word_wr, link.word_addr,
                              RRP_REG_SPEED)) begin
            // Stored as the speed of the next motion
            speed_q <= link.word_data;
        end
    end

    // Start edge detector; the previous level resets to the idle low
    // level of start, so leaving reset makes no false edge
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            // Start idles low
            start_prev_q <= 1'b0;
            start_pulse <= 1'b0;
        end else begin
            // Follow the start level
            start_prev_q <= link.forward_start;
            // Announce the latch one cycle after the edge
            start_pulse <= start_edge;
        end
    end

    // Source flag for the motion now running
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            // No motion yet
            active_from_register <= 1'b0;
        end else if (start_edge) begin
            // Mode as seen at the start edge, not later
            active_from_register <= reg_mode;
        end
    end

    // Target held for the whole motion; later writes wait for the
    // next start edge
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            // No motion yet
            active_pos <= RRP_POS_RST;
        end else if (start_edge) begin
            // Copy taken once per start
            active_pos <= next_pos;
        end
    end

    // Speed held the same way
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            // No motion yet
            active_speed <= RRP_WORD_RST;
        end else if (start_edge) begin
            // Copy taken once per start
            active_speed <= next_speed;
        end
    end

    // Absolute or incremental fixed at the start edge; a select
    // change mid-motion only counts for the next one
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            // No motion yet
            active_incremental <= 1'b0;
        end else if (start_edge) begin
            // Select bit as it stands at this edge
            active_incremental <= next_incremental;
        end
    end

    // Accel/decel constants always come from table entry 1 here, so
    // that entry must be filled before register moves run
    assign accel_entry = RRP_ACCEL_ENTRY;
endmodule : rrp_drive
`default_nettype wire

// [hw/rrp_link_if.sv]
`timescale 1ns/10ps
`default_nettype none
// Remote bits and words between master and drive
interface rrp_link_if;
    logic auto_manual_select; // High selects automatic mode
    logic register_command_select; // High selects register commands
    logic abs_inc_select; // High treats target as incremental
    logic forward_start; // Rising edge starts a motion
    logic word_wr; // One-cycle word write strobe
    logic [2:0] word_addr; // Remote word index
    logic [15:0] word_data; // Word written
    modport master (output auto_manual_select, register_command_select,
        abs_inc_select, forward_start, word_wr, word_addr, word_data);
    modport drive (input auto_manual_select, register_command_select,
        abs_inc_select, forward_start, word_wr, word_addr, word_data);
endinterface : rrp_link_if
`default_nettype wire

// [hw/rrp_master.sv]
`timescale 1ns/10ps
`default_nettype none
// Master end: drives selection bits and command words
module rrp_master
    import rrp_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    rrp_link_if.master link,
    input wire logic [31:0] user_pos,
    input wire logic [15:0] user_speed,
    input wire logic user_inc_system,
    input wire logic user_abs_inc,
    input wire logic user_go,
    output logic user_busy,
    output logic user_rejected
);
    // Sequencer states
    typedef enum logic [2:0] {
        RRP_M_IDLE = 3'b000,
        RRP_M_LOW = 3'b001,
        RRP_M_HIGH = 3'b010,
        RRP_M_SPEED = 3'b011,
        RRP_M_START = 3'b100
    } rrp_mstate_t;
    rrp_mstate_t state_q;
    logic [31:0] pos_q; // Held target
    logic [15:0] speed_q; // Held speed
    logic rej_q; // Last request out of range

    // Sequence: select bits first, then words, then start edge
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_q <= RRP_M_IDLE;
            pos_q <= RRP_POS_RST;
            speed_q <= RRP_WORD_RST;
            rej_q <= 1'b0;
        end else begin
            case (state_q)
                RRP_M_IDLE: begin
                    if (user_go) begin
                        // Out-of-range targets never go out
                        if (rrp_pos_ok(user_pos, user_inc_system)) begin
                            pos_q <= user_pos;
                            speed_q <= user_speed;
                            rej_q <= 1'b0;
                            state_q <= RRP_M_LOW;
                        end else begin
                            rej_q <= 1'b1;
                        end
                    end
                end
                RRP_M_LOW: state_q <= RRP_M_HIGH;
                RRP_M_HIGH: state_q <= RRP_M_SPEED;
                RRP_M_SPEED: state_q <= RRP_M_START;
                RRP_M_START: state_q <= RRP_M_IDLE;
                default: state_q <= RRP_M_IDLE;
            endcase
        end
    end

    // Mode bits held on while a sequence is out
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            link.auto_manual_select <= 1'b0;
            link.register_command_select <= 1'b0;
            link.abs_inc_select <= 1'b0;
        end else if (state_q == RRP_M_IDLE && user_go) begin
            // Set a few cycles before start for transfer slack
            link.auto_manual_select <= 1'b1;
            link.register_command_select <= 1'b1;
            link.abs_inc_select <= user_abs_inc;
        end
    end

    // Word writes: low half, high half, speed
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            link.word_wr <= 1'b0;
            link.word_addr <= RRP_ADDR_RST;
            link.word_data <= RRP_WORD_RST;
            link.forward_start <= 1'b0;
        end else begin
            link.word_wr <= 1'b0;
            link.forward_start <= (state_q == RRP_M_START);
            case (state_q)
                RRP_M_LOW: begin
                    link.word_wr <= 1'b1;
                    link.word_addr <= RRP_REG_POS_LOW;
                    link.word_data <= pos_q[RRP_WORD_W-1:0];
                end
                RRP_M_HIGH: begin
                    link.word_wr <= 1'b1;
                    link.word_addr <= RRP_REG_POS_HIGH;
                    link.word_data <= pos_q[RRP_POS_W-1:RRP_WORD_W];
                end
                RRP_M_SPEED: begin
                    link.word_wr <= 1'b1;
                    link.word_addr <= RRP_REG_SPEED;
                    link.word_data <= speed_q;
                end
                default: begin
                end
            endcase
        end
    end

    assign user_busy = (state_q != RRP_M_IDLE);
    assign user_rejected = rej_q;
endmodule : rrp_master
`default_nettype wire

// [hw/rrp_pkg.sv]
package rrp_pkg;
    // Remote word register indices
    localparam logic [2:0] RRP_REG_POS_LOW = 3'h4;
    localparam logic [2:0] RRP_REG_POS_HIGH = 3'h5;
    localparam logic [2:0] RRP_REG_SPEED = 3'h6;
    // Word and target widths
    localparam int RRP_WORD_W = 16;
    localparam int RRP_POS_W = 32;
    // Station count needed for register mode
    localparam logic [1:0] RRP_STATIONS_REQ = 2'h2;
    // Lowest digit codes of the parameters
    localparam logic [3:0] RRP_CMD_ABS = 4'h0;
    localparam logic [3:0] RRP_CMD_INC = 4'h1;
    localparam logic [3:0] RRP_SRC_REGISTER = 4'h2;
    // Point table entry that supplies accel/decel constants
    localparam logic [7:0] RRP_ACCEL_ENTRY = 8'h01;
    // Position target limits
    localparam logic signed [31:0] RRP_POS_MAX = 32'sd999999;
    localparam logic signed [31:0] RRP_POS_MIN = -32'sd999999;
    // Reset values
    localparam logic [15:0] RRP_WORD_RST = 16'h0000;
    localparam logic [31:0] RRP_POS_RST = 32'h0000_0000;
    localparam logic [2:0] RRP_ADDR_RST = 3'h0;
    // Lowest parameter digit sits in bits 3:0
    localparam int RRP_DIGIT_MSB = 3;

    // Legal target for the given command system
    function automatic logic rrp_pos_ok(input logic [31:0] pos,
                                        input logic inc_system);
        logic signed [31:0] p;
        p = $signed(pos);
        if (inc_system) begin
            rrp_pos_ok = (p >= 32'sd0) && (p <= RRP_POS_MAX);
        end else begin
            rrp_pos_ok = (p >= RRP_POS_MIN) && (p <= RRP_POS_MAX);
        end
    endfunction : rrp_pos_ok
endpackage : rrp_pkg

// [tb/remote_register_position_command_test.sv]
`timescale 1ns/10ps
`default_nettype none
module remote_register_position_command_test;
    import rrp_pkg::*;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [1:0] stations_occupied = 2'h2;
    logic [15:0] command_system_param = 16'h0000;
    logic [15:0] position_source_param = 16'h0002;
    logic [31:0] table_pos = 32'h0, user_pos = 32'h0, prev_pos = 32'h0;
    logic [15:0] table_speed = 16'h0bad, user_speed = 16'h0;
    logic [15:0] prev_speed = 16'h0000;
    logic prev_inc = 1'b0;
    logic user_inc_system = 1'b0, user_abs_inc = 1'b0, user_go = 1'b0;
    logic user_busy, user_rejected, start_pulse;
    logic active_incremental, active_from_register;
    logic [31:0] active_pos;
    logic [15:0] active_speed;
    logic [7:0] accel_entry;
    int n_mismatch = 0;
    int tests_run = 0;
    // Free-running 250 MHz clock
    always #2 clock = ~clock;
    rrp_link_if link ();
    rrp_master rrp_master_inst (.clock, .rst, .link, .user_pos, .user_speed,
        .user_inc_system, .user_abs_inc, .user_go, .user_busy,
        .user_rejected);
    rrp_drive rrp_drive_inst (.clock, .rst, .link, .stations_occupied,
        .command_system_param, .position_source_param, .table_pos,
        .table_speed, .start_pulse, .active_pos, .active_speed,
        .active_incremental, .active_from_register, .accel_entry);
    rrp_checker rrp_checker_inst (.clock, .rst,
        .auto_manual_select(link.auto_manual_select),
        .register_command_select(link.register_command_select),
        .abs_inc_select(link.abs_inc_select),
        .forward_start(link.forward_start), .word_wr(link.word_wr),
        .word_addr(link.word_addr), .word_data(link.word_data));
    task automatic chk(input string name, input logic [31:0] exp,
                       input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    // One full go: settings, target, then every drive output but accel_entry
    task automatic run(input logic [1:0] st, input logic [3:0] cs,
                       input logic [3:0] src, input logic [31:0] pos,
                       input logic ai);
        logic reg_m, inc, rej, seen;
        logic signed [31:0] p;
        p = pos;
        reg_m = (st == RRP_STATIONS_REQ) && (src == RRP_SRC_REGISTER);
        inc = (cs == RRP_CMD_INC) || ai;
        rej = (p > RRP_POS_MAX) ||
              (p < ((cs == RRP_CMD_INC) ? 32'sh0 : RRP_POS_MIN));
        @(posedge clock);
        #1;
        stations_occupied = st;
        command_system_param = {12'h000, cs};
        position_source_param = {12'h000, src};
        table_pos = ~pos;
        user_pos = pos;
        user_speed = pos[15:0] ^ 16'h5a5a;
        user_inc_system = (cs == RRP_CMD_INC);
        user_abs_inc = ai;
        user_go = 1'b1;
        @(posedge clock);
        #1;
        user_go = 1'b0;
        seen = 1'b0;
        // Old command must hold until the new start edge
        for (int i = 0; i < 20 && !seen; i++) begin
            @(posedge clock);
            #1;
            seen = (start_pulse === 1'b1);
            // Busy while the words go out, idle after a refusal
            if (i == 0) chk("user_busy run", !rej, user_busy);
            if (!seen) begin
                chk("active_pos held", prev_pos, active_pos);
                chk("active_speed held", prev_speed, active_speed);
                chk("active_inc held", prev_inc, active_incremental);
            end
        end
        chk("start_pulse", {31'h0, !rej}, {31'h0, seen});
        chk("user_rejected", {31'h0, rej}, {31'h0, user_rejected});
        if (seen) begin
            prev_pos = reg_m ? pos : ~pos;
            prev_speed = reg_m ? user_speed : table_speed;
            prev_inc = inc;
            chk("active_pos", prev_pos, active_pos);
            chk("active_speed", reg_m ? user_speed : table_speed,
                active_speed);
            chk("active_inc", inc, active_incremental);
            chk("from_reg", reg_m, active_from_register);
            chk("user_busy", 32'h0, user_busy);
        end
    endtask : run
    task automatic end_sim;
        $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_sim
    // Watchdog: all runs finish well within this span
    initial begin
        #20000;
        n_mismatch++;
        end_sim;
    end
    initial begin
        repeat (16) @(posedge clock);
        #1 rst = 1'b0;
        chk("accel_entry", 32'h1, accel_entry);
        run(2'h2, RRP_CMD_ABS, RRP_SRC_REGISTER, RRP_POS_MIN, 1'b0);
        run(2'h2, RRP_CMD_ABS, RRP_SRC_REGISTER, RRP_POS_MAX, 1'b1);
        run(2'h2, RRP_CMD_INC, RRP_SRC_REGISTER, 32'h0, 1'b0);
        run(2'h2, RRP_CMD_INC, RRP_SRC_REGISTER, 32'hffffffff, 1'b0);
        run(2'h2, RRP_CMD_ABS, RRP_SRC_REGISTER, 32'h000f4240, 1'b0);
        run(2'h1, RRP_CMD_ABS, RRP_SRC_REGISTER, 32'h00001234, 1'b0);
        run(2'h2, RRP_CMD_INC, 4'h0, 32'h00004321, 1'b1);
        run(2'h2, RRP_CMD_ABS, RRP_SRC_REGISTER, 32'h00012345, 1'b0);
        chk("accel_entry", 32'h1, accel_entry);
        end_sim;
    end
endmodule : remote_register_position_command_test
`default_nettype wire

// [tb/rrp_checker.sv]
`timescale 1ns/10ps
`default_nettype none
// Watches the master-to-drive link from the side
module rrp_checker (
    input wire logic clock,
    input wire logic rst,
    input wire logic auto_manual_select,
    input wire logic register_command_select,
    input wire logic abs_inc_select,
    input wire logic forward_start,
    input wire logic word_wr,
    input wire logic [2:0] word_addr,
    input wire logic [15:0] word_data
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // Only the three command words are written
    a_addr_in_map: assert property (
        word_wr |-> word_addr inside {3'h4, 3'h5, 3'h6})
        else $error("Word index outside the map");
    // Low half goes first, high half right behind
    a_low_then_high: assert property (
        word_wr && word_addr == 3'h4 |=> word_wr && word_addr == 3'h5)
        else $error("High word did not follow low word");
    a_high_then_speed: assert property (
        word_wr && word_addr == 3'h5 |=> word_wr && word_addr == 3'h6)
        else $error("Speed word did not follow high word");
    // Start only once all words have landed
    a_speed_then_start: assert property (
        word_wr && word_addr == 3'h6 |=> forward_start && !word_wr)
        else $error("Start did not follow speed word");
    a_start_one_cycle: assert property (
        $rose(forward_start) |=> !forward_start)
        else $error("Start held longer than one cycle");
    a_modes_at_start: assert property (
        forward_start |-> auto_manual_select && register_command_select)
        else $error("Start without both mode selects");
    // Register and abs/inc selects settle before words, so latency cannot split them
    a_modes_steady: assert property (
        word_wr |-> $stable(abs_inc_select) && $stable(register_command_select))
        else $error("Select moved while words were sent");
    a_start_after_words: assert property (
        $rose(forward_start) |-> $past(word_wr) && $past(word_addr) == 3'h6)
        else $error("Start without a preceding speed word");
endmodule : rrp_checker
`default_nettype wire
